// >>> rtl/return_stack_pointer_logic.sv
`timescale 1ns/1ps
`include "rsp_cfg.svh"
// Notes on behaviour
// - the pointer is five bits and covers 0 to 31.
// - a push bumps the pointer then writes; a pop reads then drops it.
// - the general reset (presetn) and the overflow reset bring the pointer to zero; power-on reset alone does not.
// - software may read and overwrite the pointer value.
// - the full flag sets after 31 pushes without a pop.
// - the full flag holds until software clears it or power-on reset.
// - with overflow reset on, push 31 stores pc+2, sets full, resets core.
// - with it off, push 31 sets full, pointer 31, later pushes ignored.
// - a pop at zero returns pc zero, sets underflow, pointer stays zero.
// - underflow holds until software clears it or power-on reset.
// - the underflow vector is not a reset and leaves registers alone.
// - the top entry is readable and writable as three byte registers.
// - the push instruction bumps the pointer and stores the current pc.
// - the pop instruction drops the top entry by decrementing.
// - full at bit 7, underflow bit 6, bit 5 zero, pointer in 4 to 0.
module return_stack_pointer_logic
	import rsp_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        por_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        push_req,
	input  wire logic        pop_req,
	input  wire logic [20:0] pc_in,
	output logic      [20:0] ret_pc,
	output logic             ret_valid,
	output logic             core_reset_req
);
	ptr_t       ptr_r;
	ptr_t       ptr_nxt;
	logic       full_r;
	logic       unf_r;
	logic       ore_r;
	pc_t        last_pc_r;
	ovf_state_e ovf_r;
	logic       acc;
	logic       wr_acc;
	logic       rd_acc;
	logic       unmapped;
	logic       do_push;
	logic       do_pop;
	logic       ovf_push;
	logic       ptr_wr;
	logic       full_clr;
	logic       unf_clr;
	logic       pop_unf;
	logic [31:0] rd_mux;

	stack_if sif ();

	stack_store u_store (
		.pclk    (pclk),
		.presetn (presetn),
		.sif     (sif)
	);

	// bus decode; every access completes in its first access cycle
	assign acc    = psel && penable;
	assign wr_acc = acc && pwrite;
	assign rd_acc = acc && !pwrite;
	always_comb begin
		if (paddr == `ADDR_STKREG)
			unmapped = 1'b0;
		else if (paddr == `ADDR_TOP_LOW)
			unmapped = 1'b0;
		else if (paddr == `ADDR_TOP_HIGH)
			unmapped = 1'b0;
		else if (paddr == `ADDR_TOP_UPPER)
			unmapped = 1'b0;
		else if (paddr == `ADDR_CTRL)
			unmapped = 1'b0;
		else if (paddr == `ADDR_LAST_PC)
			unmapped = 1'b0;
		else
			unmapped = 1'b1;
	end

	// core requests are ignored while the overflow reset is in flight
	assign do_push = push_req && !pop_req && ovf_r == ST_IDLE;
	assign do_pop  = pop_req && !push_req && ovf_r == ST_IDLE;
	assign ovf_push = do_push && ptr_r == (`PTR_MAX - 5'h01);
	assign pop_unf  = do_pop && ptr_r == `PTR_ZERO;
	assign ptr_wr   = wr_acc && paddr == `ADDR_STKREG;
	// writing zero clears, writing one keeps: clear-only bits
	assign full_clr = ptr_wr && !pwdata[`FULL_BIT];
	assign unf_clr  = ptr_wr && !pwdata[`UNF_BIT];

	// next pointer; core events win over a same-cycle software write
	always_comb begin
		ptr_nxt = ptr_r;
		if (ovf_r == ST_RESET) begin
			ptr_nxt = `PTR_ZERO;
		end else if (do_push) begin
			// a push at 31 is dropped, so a write cannot sneak in
			if (ptr_r != `PTR_MAX)
				ptr_nxt = ptr_r + 5'h01;
		end else if (do_pop) begin
			// a pop at zero keeps the pointer at zero
			if (ptr_r != `PTR_ZERO)
				ptr_nxt = ptr_r - 5'h01;
		end else if (ptr_wr) begin
			ptr_nxt = pwdata[`PTR_MSB:0];
		end
	end

	// pointer; saturates at 31 and at 0 through ptr_nxt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ptr_r <= `PTR_ZERO;
		else
			ptr_r <= ptr_nxt;
	end

	// store port: push writes at the bumped index, bytes at the top
	always_comb begin
		sif.wr_idx    = ptr_r;
		sif.wr_en     = 1'b0;
		sif.wr_data   = pc_in;
		sif.byte_we   = 3'b000;
		sif.byte_data = pwdata[7:0];
		sif.rd_idx    = ptr_r;
		if (do_push && ptr_r != `PTR_MAX) begin
			sif.wr_idx = ptr_r + 5'h01;
			sif.wr_en  = 1'b1;
			if (ovf_push && ore_r)
				sif.wr_data = pc_in + `PC_STEP;
		end else if (wr_acc) begin
			// top-entry byte writes hit the entry under the pointer
			sif.byte_we[0] = paddr == `ADDR_TOP_LOW;
			sif.byte_we[1] = paddr == `ADDR_TOP_HIGH;
			sif.byte_we[2] = paddr == `ADDR_TOP_UPPER;
		end
	end

	// full flag lives on power-on reset only; set beats clear
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n)
			full_r <= 1'b0;
		else if (ovf_push)
			full_r <= 1'b1;
		else if (full_clr)
			full_r <= 1'b0;
	end

	// underflow flag, same retention as the full flag
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n)
			unf_r <= 1'b0;
		else if (pop_unf)
			unf_r <= 1'b1;
		else if (unf_clr)
			unf_r <= 1'b0;
	end

	// overflow reset enable; configuration, so kept across core resets
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n)
			ore_r <= `CTRL_RESET;
		else if (wr_acc && paddr == `ADDR_CTRL)
			ore_r <= pwdata[`CTRL_ORE_BIT];
	end

	// overflow sequencer: one-cycle core reset then zero the pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_r <= ST_IDLE;
		end else begin
			case (ovf_r)
			ST_IDLE: begin
				if (ovf_push && ore_r)
					ovf_r <= ST_RESET;
			end
			ST_RESET: ovf_r <= ST_HOLD;
			ST_HOLD:  ovf_r <= ST_IDLE;
			default:  ovf_r <= ST_IDLE;
			endcase
		end
	end

	// reset request to the core, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			core_reset_req <= 1'b0;
		else
			core_reset_req <= ovf_push && ore_r;
	end

	// return address; underflow returns zero and is no reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ret_pc    <= 21'h000000;
			ret_valid <= 1'b0;
		end else begin
			ret_valid <= do_pop;
			if (pop_unf)
				ret_pc <= 21'h000000;
			else if (do_pop)
				ret_pc <= sif.rd_data;
		end
	end

	// last pushed pc, status aid for software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			last_pc_r <= 21'h000000;
		else if (do_push)
			last_pc_r <= pc_in;
	end

	// read mux
	always_comb begin
		rd_mux = 32'h00000000;
		if (paddr == `ADDR_STKREG)
			rd_mux = {24'h000000, full_r, unf_r, 1'b0, ptr_r};
		else if (paddr == `ADDR_TOP_LOW)
			rd_mux = {24'h000000, sif.rd_data[7:0]};
		else if (paddr == `ADDR_TOP_HIGH)
			rd_mux = {24'h000000, sif.rd_data[15:8]};
		else if (paddr == `ADDR_TOP_UPPER)
			rd_mux = {27'h0000000, sif.rd_data[20:16]};
		else if (paddr == `ADDR_CTRL)
			rd_mux = {31'h00000000, ore_r};
		else if (paddr == `ADDR_LAST_PC)
			rd_mux = {11'h000, last_pc_r};
	end

	// answer registered: pready high in the cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && unmapped;
			if (psel && !penable && !pwrite)
				prdata <= rd_mux;
		end
	end

	// underflow pop keeps the pointer at zero
	a_unf_ptr_zero: assert property (@(posedge pclk)
		disable iff (!presetn)
		pop_unf |=> ptr_r == 5'h00 && unf_r)
		else $error("underflow pop moved pointer");
	// push increments, pop decrements
	a_push_incr: assert property (@(posedge pclk)
		disable iff (!presetn)
		do_push && ptr_r < 5'h1f && !ovf_push |=> ptr_r == $past(ptr_r) + 5'h01)
		else $error("push did not increment");
	a_pop_decr: assert property (@(posedge pclk)
		disable iff (!presetn)
		do_pop && ptr_r != 5'h00 |=> ptr_r == $past(ptr_r) - 5'h01)
		else $error("pop did not decrement");
	// the pushed pc lands in the new top entry
	a_push_store: assert property (@(posedge pclk)
		disable iff (!presetn)
		do_push && ptr_r != 5'h1f && !(ovf_push && ore_r)
		|=> sif.rd_data == $past(pc_in))
		else $error("push did not store pc");
	// a pop hands back the entry under the pointer
	a_pop_ret: assert property (@(posedge pclk)
		disable iff (!presetn)
		do_pop && ptr_r != 5'h00
		|=> ret_valid && ret_pc == $past(sif.rd_data))
		else $error("pop returned wrong entry");
	// general reset holds the pointer at zero
	a_reset_ptr: assert property (@(posedge pclk)
		!presetn |-> ptr_r == 5'h00)
		else $error("pointer not zero in reset");
	// software pointer write when no core event competes
	a_sw_ptr_wr: assert property (@(posedge pclk)
		disable iff (!presetn)
		ptr_wr && !do_push && !do_pop && ovf_r != ST_RESET
		|=> ptr_r == $past(pwdata[4:0]))
		else $error("pointer write lost");
	// overflow with reset on: pc plus two, one pulse, pointer zero
	a_ovf_reset: assert property (@(posedge pclk)
		disable iff (!presetn)
		ovf_push && ore_r |=> core_reset_req ##1 ptr_r == 5'h00)
		else $error("overflow reset sequence wrong");
	a_ovf_pc_step: assert property (@(posedge pclk)
		disable iff (!presetn)
		ovf_push && ore_r |=> sif.rd_data == $past(pc_in) + `PC_STEP)
		else $error("overflow entry not pc plus two");
	a_rst_pulse: assert property (@(posedge pclk)
		disable iff (!presetn)
		core_reset_req |=> !core_reset_req)
		else $error("core reset longer than one cycle");
	// overflow with reset off: pointer and entry 31 frozen
	a_ovf_sat: assert property (@(posedge pclk)
		disable iff (!presetn)
		ptr_r == 5'h1f && do_push && !ore_r |=> ptr_r == 5'h1f)
		else $error("saturated pointer moved");
	a_sat_no_write: assert property (@(posedge pclk)
		disable iff (!presetn)
		do_push && ptr_r == 5'h1f |-> !sif.wr_en)
		else $error("saturated push wrote an entry");
	// sticky flags: set by events, cleared by software or power-on
	a_full_set: assert property (@(posedge pclk)
		disable iff (!por_n)
		ovf_push |=> full_r)
		else $error("full flag not set");
	a_full_sticky: assert property (@(posedge pclk)
		disable iff (!por_n)
		full_r && !full_clr |=> full_r)
		else $error("full flag lost");
	a_full_clr: assert property (@(posedge pclk)
		disable iff (!por_n)
		full_clr && !ovf_push |=> !full_r)
		else $error("full flag not cleared");
	a_unf_sticky: assert property (@(posedge pclk)
		disable iff (!por_n)
		unf_r && !unf_clr |=> unf_r)
		else $error("underflow flag lost");
	a_unf_clr: assert property (@(posedge pclk)
		disable iff (!por_n)
		unf_clr && !pop_unf |=> !unf_r)
		else $error("underflow flag not cleared");
	// underflow return is zero and disturbs no register
	a_unf_ret_zero: assert property (@(posedge pclk)
		disable iff (!presetn)
		pop_unf |=> ret_valid && ret_pc == 21'h000000 && !core_reset_req)
		else $error("underflow return not zero");
	a_unf_no_reset: assert property (@(posedge pclk)
		disable iff (!presetn || !por_n)
		pop_unf && !wr_acc
		|=> $stable(ore_r) && $stable(full_r) && $stable(last_pc_r))
		else $error("underflow disturbed a register");
	// status register layout and bus answer timing
	a_stk_fmt: assert property (@(posedge pclk)
		disable iff (!presetn)
		psel && !penable && !pwrite && paddr == `ADDR_STKREG
		|=> prdata[31:8] == 24'h000000 && !prdata[5])
		else $error("status register layout wrong");
	a_pready_once: assert property (@(posedge pclk)
		disable iff (!presetn)
		psel && !penable |=> pready ##1 !pready)
		else $error("pready not a single access cycle");
endmodule

// >>> rtl/rsp_cfg.svh
`ifndef RSP_CFG_SVH
`define RSP_CFG_SVH
// register byte addresses on the bus
`define ADDR_STKREG     12'h000
`define ADDR_TOP_LOW    12'h004
`define ADDR_TOP_HIGH   12'h008
`define ADDR_TOP_UPPER  12'h00c
`define ADDR_CTRL       12'h010
`define ADDR_LAST_PC    12'h014
// pointer register fields
`define FULL_BIT        7
`define UNF_BIT         6
`define PTR_MSB         4
// pointer limits
`define PTR_MAX         5'h1f
`define PTR_ZERO        5'h00
// control register: bit 0 overflow reset enable, reset value 1
`define CTRL_ORE_BIT    0
`define CTRL_RESET      1'b1
// program counter increment stored by the overflowing push
`define PC_STEP         21'h000002
`endif

// >>> rtl/rsp_pkg.sv
package rsp_pkg;
	typedef logic [4:0]  ptr_t;
	typedef logic [20:0] pc_t;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_RESET = 3'b010,
		ST_HOLD  = 3'b100
	} ovf_state_e;
endpackage

// >>> rtl/stack_if.sv
`timescale 1ns/1ps
// write/read port between the pointer logic and the entry store
interface stack_if;
	logic [4:0]  wr_idx;
	logic        wr_en;
	logic [20:0] wr_data;
	logic [2:0]  byte_we;
	logic [7:0]  byte_data;
	logic [4:0]  rd_idx;
	logic [20:0] rd_data;
	modport ctrl  (output wr_idx, wr_en, wr_data, byte_we, byte_data,
		rd_idx, input rd_data);
	modport store (input wr_idx, wr_en, wr_data, byte_we, byte_data,
		rd_idx, output rd_data);
endinterface

// >>> rtl/stack_store.sv
`timescale 1ns/1ps
// entry storage; reads are combinational so a pop sees the top at once
module stack_store
	import rsp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	stack_if.store   sif
);
	logic [20:0] mem [0:31];

	genvar i;
	generate
		for (i = 0; i < 32; i++) begin : g_entry
			// whole-entry push or per-byte software write
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mem[i] <= 21'h000000;
				end else if (sif.wr_idx == 5'(i)) begin
					if (sif.wr_en) begin
						mem[i] <= sif.wr_data;
					end else begin
						if (sif.byte_we[0])
							mem[i][7:0] <= sif.byte_data;
						if (sif.byte_we[1])
							mem[i][15:8] <= sif.byte_data;
						if (sif.byte_we[2])
							mem[i][20:16] <= sif.byte_data[4:0];
					end
				end
			end
		end
	endgenerate

	assign sif.rd_data = mem[sif.rd_idx];
endmodule

// >>> testbench/core_seq.sv
`timescale 1ns/1ps
// stand-in for the instruction sequencer: one-cycle push/pop requests
module core_seq
	import rsp_pkg::*;
(
	input  wire logic pclk,
	input  wire pc_t  ret_pc,
	input  wire logic ret_valid,
	output logic      push_req,
	output logic      pop_req,
	output pc_t       pc_in
);
	initial begin
		push_req = 1'b0;
		pop_req  = 1'b0;
		pc_in    = '0;
	end
	// released pc lines flip, so a stale value never passes as data
	task push(input pc_t pc);
		@(posedge pclk);
		push_req <= 1'b1;
		pc_in    <= pc;
		@(posedge pclk);
		push_req <= 1'b0;
		pc_in    <= ~pc;
	endtask
	// result sampled one cycle after the pop is taken
	task pop(output pc_t q, output logic v);
		@(posedge pclk);
		pop_req <= 1'b1;
		@(posedge pclk);
		pop_req <= 1'b0;
		@(posedge pclk);
		q = ret_pc;
		v = ret_valid;
	endtask
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`include "rsp_cfg.svh"
module tb_top
	import rsp_pkg::*;
;
	logic        pclk, presetn, por_n, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, seed;
	logic        pready, pslverr, push_req, pop_req, ret_valid;
	logic        core_reset_req, e, v;
	pc_t         pc_in, ret_pc, tv, r, x;
	pc_t         stk [32];
	int          fails, total_checks, i, n, rst_seen = 0;

	return_stack_pointer_logic uut (.pclk(pclk), .presetn(presetn),
		.por_n(por_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .push_req(push_req), .pop_req(pop_req),
		.pc_in(pc_in), .ret_pc(ret_pc), .ret_valid(ret_valid),
		.core_reset_req(core_reset_req));
	core_seq cs (.pclk(pclk), .ret_pc(ret_pc), .ret_valid(ret_valid),
		.push_req(push_req), .pop_req(pop_req), .pc_in(pc_in));

	always #2 pclk = ~pclk;
	// count core reset pulses
	always @(posedge pclk) if (core_reset_req === 1'b1) rst_seen++;

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task chk(input string nm, input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask

	// one apb transfer; waits for pready, only the watchdog ends a hang
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rtop();
		apb(0, `ADDR_TOP_LOW, 0);
		tv[7:0] = q[7:0];
		apb(0, `ADDR_TOP_HIGH, 0);
		tv[15:8] = q[7:0];
		apb(0, `ADDR_TOP_UPPER, 0);
		tv[20:16] = q[4:0];
	endtask

	task fill(input int m);
		for (int j = 1; j <= m; j++) begin
			stk[j] = rnd();
			cs.push(stk[j]);
		end
	endtask

	task final_report();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// whole run is a few hundred cycles
	initial begin
		#200000;
		fails++;
		final_report();
	end

	initial begin
		pclk = 0; presetn = 0; por_n = 0; psel = 0; penable = 0;
		pwrite = 0; paddr = 0; pwdata = 0; seed = 32'd54104;
		fails = 0; total_checks = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		apb(0, `ADDR_STKREG, 0); chk("ptr", q, 0);
		apb(0, 12'h3f0, 0); chk("slverr", e, 1);
		chk("unmapped rd", q, 0);
		$display("test reset done");
		n = 2 + rnd() % 6;
		fill(n);
		apb(0, `ADDR_STKREG, 0); chk("ptr", q, n);
		rtop(); chk("top", tv, stk[n]);
		x = stk[n];
		apb(1, `ADDR_TOP_LOW, 32'h5a);
		apb(1, `ADDR_TOP_HIGH, 32'ha5);
		apb(1, `ADDR_TOP_UPPER, 32'h13);
		stk[n] = {5'h13, 8'ha5, 8'h5a};
		rtop(); chk("top wr", tv, stk[n]);
		for (i = n; i >= 1; i--) begin
			cs.pop(r, v);
			chk("pop", r, stk[i]);
			chk("valid", v, 1);
		end
		cs.pop(r, v); chk("unf pc", r, 0);
		chk("unf valid", v, 1);
		apb(0, `ADDR_STKREG, 0); chk("unf", q, 32'h40);
		apb(0, `ADDR_CTRL, 0); chk("ctrl", q, 1);
		apb(0, `ADDR_LAST_PC, 0); chk("last pc", q, x);
		apb(1, `ADDR_STKREG, 32'h03);
		apb(0, `ADDR_STKREG, 0); chk("ptr wr", q, 3);
		$display("test push pop done");
		// saturating overflow
		apb(1, `ADDR_CTRL, 0);
		apb(1, `ADDR_STKREG, 0);
		fill(31);
		apb(0, `ADDR_STKREG, 0); chk("full", q, 32'h9f);
		cs.push(rnd());
		apb(0, `ADDR_STKREG, 0); chk("sat", q, 32'h9f);
		rtop(); chk("kept", tv, stk[31]);
		chk("no rst", rst_seen, 0);
		$display("test saturate done");
		// overflow with core reset
		apb(1, `ADDR_STKREG, 0);
		apb(1, `ADDR_CTRL, 1);
		fill(31);
		x = stk[31] + 21'd2;
		repeat (3) @(posedge pclk);
		chk("rst", rst_seen, 1);
		apb(0, `ADDR_STKREG, 0); chk("ovf", q, 32'h80);
		apb(1, `ADDR_STKREG, 32'h9f);
		rtop(); chk("pc+2", tv, x);
		apb(1, `ADDR_CTRL, 0);
		@(posedge pclk) presetn <= 1'b0;
		@(posedge pclk) presetn <= 1'b1;
		apb(0, `ADDR_STKREG, 0); chk("sticky", q, 32'h80);
		apb(0, `ADDR_CTRL, 0); chk("ctrl kept", q, 0);
		@(posedge pclk) begin
			presetn <= 1'b0;
			por_n <= 1'b0;
		end
		@(posedge pclk) begin
			presetn <= 1'b1;
			por_n <= 1'b1;
		end
		apb(0, `ADDR_STKREG, 0); chk("por", q, 0);
		apb(0, `ADDR_CTRL, 0); chk("ctrl por", q, 1);
		$display("test overflow done");
		final_report();
	end
endmodule
